// ===== cpr_bank.sv
// Purpose: page 0 command register bank: page select, command/power, irq enable
// Assumes: host requests come from interface logic on the same clock
// Notes: one-cycle read latency; writes land at the edge that takes them
//
// How it works
// - r/w bits change only by host writes; internal logic just reads them.
// - dynamic bits accept host writes and internal updates alike.
// - read-only bits show internal status; host writes to them do nothing.
// - reads of a write-only register always return zero.
// - reserved bits and registers read back as zero.
// - with page override set, page number gives A5..A4, pins give low bits.
// - with page override clear, the address latch alone gives the address.
// - page number lives in bits 1..0, used only while override is set.
// - command bit 5 set switches the receiver analog section off.
// - writing 1 to soft sleep enters soft power-down.
// - writing 0 starts wake-up; bit reads 1 until wake-up completes.
// - soft sleep cannot be set while self reinit command runs.
// - writing the command field starts that command.
// - reading the command field shows the command now executing.
// - page select resets to 00h.
// - command register resets to 20h.
// - irq enable at 02h resets to 80h: polarity bit plus seven enables.
// - polarity bit set inverts the irq pin against the combined status.
// - each enable lets only its own request reach the irq pin.
`timescale 1ns/100ps

module cpr_bank
  import cpr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire cpr_req_t host_req,
  output cpr_rsp_t host_rsp,
  output logic [5:0] reg_addr,
  output logic rx_analog_off,
  output logic soft_sleep,
  output logic cmd_start,
  output logic [3:0] cmd_code,
  input wire logic cmd_done,
  input wire logic wake_ready,
  input wire logic checksum_done_flag,
  input wire logic [6:0] irq_flags,
  output logic irq_pin,
  output logic flag_force_strobe,
  output logic [7:0] flag_force_data
);

  // ==========================================================
  // power state
  // waking is a state of its own so the read bit stays high after the sleep level drops
  typedef enum logic [2:0] {
    CPR_PWR_AWAKE = 3'b001,
    CPR_PWR_ASLEEP = 3'b010,
    CPR_PWR_WAKING = 3'b100
  } cpr_pwr_state_t;

  // ==========================================================
  // registers
  logic page_override_en;
  logic [1:0] page_number;
  cpr_pwr_state_t pwr_state;
  logic sleep_req;
  logic waking;
  logic [3:0] cmd_run;
  logic irq_polarity_flip;
  logic [6:0] irq_allow;
  logic [7:0] rd_data;
  logic rd_valid;
  logic rd_hit;
  logic irq_out;
  logic start_pulse;
  logic force_pulse;
  logic [7:0] force_data;

  // ==========================================================
  // address formation
  wire logic [5:0] eff_addr;
  wire logic [3:0] low_addr;
  wire logic [1:0] page_addr;

  // the pins supply the low nibble only while the override is on
  assign low_addr = page_override_en ? host_req.pin_addr : host_req.latch_addr[3:0];
  assign page_addr = page_override_en ? page_number : host_req.latch_addr[5:4];
  assign eff_addr = {page_addr, low_addr};
  assign reg_addr = eff_addr;

  // ==========================================================
  // decode
  wire logic in_page0;
  wire logic sel_page;
  wire logic sel_cmd;
  wire logic sel_ien;
  wire logic sel_status;
  wire logic sel_force;
  wire logic sel_any;

  assign in_page0 = eff_addr[5:4] == CPR_PAGE_CMD;
  // page select answers at offset 0 of every page, so software can always leave a page
  assign sel_page = low_addr == CPR_OFS_PAGE_SELECT;
  assign sel_cmd = in_page0 && (low_addr == CPR_OFS_COMMAND);
  assign sel_ien = in_page0 && (low_addr == CPR_OFS_IRQ_ENABLE);
  assign sel_status = in_page0 && (low_addr == CPR_OFS_STATUS);
  assign sel_force = in_page0 && (low_addr == CPR_OFS_FLAG_FORCE);
  assign sel_any = sel_page | sel_cmd | sel_ien | sel_status | sel_force;

  wire logic wr_page;
  wire logic wr_cmd;
  wire logic wr_ien;
  wire logic wr_force;

  assign wr_page = host_req.wr && sel_page;
  assign wr_cmd = host_req.wr && sel_cmd;
  assign wr_ien = host_req.wr && sel_ien;
  // status is read-only: no write strobe exists for it
  assign wr_force = host_req.wr && sel_force;

  // ==========================================================
  // command and power next values
  wire logic reinit_running;
  wire logic wr_sleep_bit;
  wire logic sleep_set_ok;
  cpr_pwr_state_t next_pwr_state;
  logic [3:0] next_cmd_run;

  assign reinit_running = cmd_run == CPR_CMD_SELF_REINIT;
  assign wr_sleep_bit = host_req.wdata[CPR_BIT_SOFT_SLEEP];
  // judged against the command already running, not the one being written
  assign sleep_set_ok = !reinit_running;

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      CPR_PWR_AWAKE: begin
        if (wr_cmd && wr_sleep_bit && sleep_set_ok) begin
          next_pwr_state = CPR_PWR_ASLEEP;
        end
      end
      CPR_PWR_ASLEEP: begin
        if (wr_cmd && !wr_sleep_bit) begin
          // leaving power-down keeps the bit visible until the core is ready
          next_pwr_state = CPR_PWR_WAKING;
        end
      end
      CPR_PWR_WAKING: begin
        // a new sleep request beats a wake-up that completes in the same cycle
        if (wr_cmd && wr_sleep_bit && sleep_set_ok) begin
          next_pwr_state = CPR_PWR_ASLEEP;
        end else if (wake_ready) begin
          next_pwr_state = CPR_PWR_AWAKE;
        end
      end
      default: begin
        next_pwr_state = CPR_PWR_AWAKE;
      end
    endcase
  end

  assign sleep_req = pwr_state == CPR_PWR_ASLEEP;
  assign waking = pwr_state == CPR_PWR_WAKING;

  always_comb begin
    next_cmd_run = cmd_run;
    if (cmd_done) begin
      next_cmd_run = CPR_CMD_IDLE;
    end
    // a host write in the same cycle wins over the end of the old command
    if (wr_cmd) begin
      next_cmd_run = host_req.wdata[CPR_CMD_HI:0];
    end
  end

  // ==========================================================
  // read data
  wire logic [7:0] page_view;
  wire logic [7:0] cmd_view;
  wire logic [7:0] ien_view;
  wire logic [7:0] status_view;
  wire logic [7:0] rd_mux;

  assign page_view = {page_override_en, 5'h00, page_number};
  assign cmd_view = {2'h0, rx_analog_off, sleep_req | waking, cmd_run};
  assign ien_view = {irq_polarity_flip, irq_allow};
  assign status_view = {7'h00, checksum_done_flag};

  // force register is write-only; other page 0 offsets are reserved
  assign rd_mux = sel_page ? page_view :
                  sel_cmd ? cmd_view :
                  sel_ien ? ien_view :
                  sel_status ? status_view :
                  8'h00;

  // ==========================================================
  // interrupt pin
  wire logic irq_any;

  assign irq_any = |(irq_flags & irq_allow);

  // ==========================================================
  // host writable registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      page_override_en <= CPR_RST_PAGE_SELECT[CPR_BIT_PAGE_OVERRIDE];
      page_number <= CPR_RST_PAGE_SELECT[CPR_PAGE_NUM_HI:0];
    end else if (wr_page) begin
      // reserved bits 6..2 are not stored whatever the host writes
      page_override_en <= host_req.wdata[CPR_BIT_PAGE_OVERRIDE];
      page_number <= host_req.wdata[CPR_PAGE_NUM_HI:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_analog_off <= CPR_RST_COMMAND[CPR_BIT_RX_OFF];
    end else if (wr_cmd) begin
      rx_analog_off <= host_req.wdata[CPR_BIT_RX_OFF];
    end
  end

  // the reset state follows the sleep bit of the command reset value
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_state <= CPR_RST_COMMAND[CPR_BIT_SOFT_SLEEP] ? CPR_PWR_ASLEEP : CPR_PWR_AWAKE;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_run <= CPR_RST_COMMAND[CPR_CMD_HI:0];
    end else begin
      cmd_run <= next_cmd_run;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_polarity_flip <= CPR_RST_IRQ_ENABLE[CPR_BIT_IRQ_FLIP];
      irq_allow <= CPR_RST_IRQ_ENABLE[CPR_IRQ_SRC_N-1:0];
    end else if (wr_ien) begin
      irq_polarity_flip <= host_req.wdata[CPR_BIT_IRQ_FLIP];
      irq_allow <= host_req.wdata[CPR_IRQ_SRC_N-1:0];
    end
  end

  // ==========================================================
  // pulses, read port and pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_pulse <= 1'b0;
      force_pulse <= 1'b0;
    end else begin
      start_pulse <= wr_cmd;
      force_pulse <= wr_force;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      force_data <= 8'h00;
    end else if (wr_force) begin
      force_data <= host_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= host_req.rd;
      rd_hit <= host_req.rd && sel_any;
      rd_data <= host_req.rd ? rd_mux : 8'h00;
    end
  end

  // the pin settles one cycle after a flag or enable change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_out <= CPR_RST_IRQ_ENABLE[CPR_BIT_IRQ_FLIP];
    end else begin
      irq_out <= irq_any ^ irq_polarity_flip;
    end
  end

  // ==========================================================
  // outputs
  assign host_rsp.valid = rd_valid;
  assign host_rsp.hit = rd_hit;
  assign host_rsp.data = rd_data;
  assign soft_sleep = sleep_req;
  assign cmd_start = start_pulse;
  assign cmd_code = cmd_run;
  assign irq_pin = irq_out;
  assign flag_force_strobe = force_pulse;
  assign flag_force_data = force_data;

endmodule : cpr_bank

// ===== cpr_pkg.sv
// Purpose: constants and carriers for the command page register bank
// Assumes: one clock, byte-wide register access from the host interface logic
// Notes: offsets are low-nibble register numbers inside page 0
package cpr_pkg;

  // ==========================================================
  // address layout
  localparam int CPR_ADDR_W = 6;
  localparam int CPR_DATA_W = 8;
  localparam logic [1:0] CPR_PAGE_CMD = 2'h0;
  localparam logic [3:0] CPR_OFS_PAGE_SELECT = 4'h0;
  localparam logic [3:0] CPR_OFS_COMMAND = 4'h1;
  localparam logic [3:0] CPR_OFS_IRQ_ENABLE = 4'h2;
  localparam logic [3:0] CPR_OFS_STATUS = 4'hB;
  localparam logic [3:0] CPR_OFS_FLAG_FORCE = 4'hC;

  // ==========================================================
  // reset values
  localparam logic [7:0] CPR_RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] CPR_RST_COMMAND = 8'h20;
  localparam logic [7:0] CPR_RST_IRQ_ENABLE = 8'h80;

  // ==========================================================
  // field positions
  localparam int CPR_BIT_PAGE_OVERRIDE = 7;
  localparam int CPR_PAGE_NUM_HI = 1;
  localparam int CPR_BIT_RX_OFF = 5;
  localparam int CPR_BIT_SOFT_SLEEP = 4;
  localparam int CPR_CMD_HI = 3;
  localparam int CPR_BIT_IRQ_FLIP = 7;
  localparam int CPR_IRQ_SRC_N = 7;

  // ==========================================================
  // command codes this bank needs to know about
  localparam logic [3:0] CPR_CMD_IDLE = 4'h0;
  localparam logic [3:0] CPR_CMD_SELF_REINIT = 4'hF;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] latch_addr;
    logic [3:0] pin_addr;
    logic [7:0] wdata;
  } cpr_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } cpr_rsp_t;

endpackage : cpr_pkg

// ===== cpr_bank_assertions.sv
// Purpose: port checks for cpr_bank
// Assumes: one clock, async active-low reset
// Notes: shadows page select and irq enable to predict outputs
`timescale 1ns/100ps
module cpr_bank_assertions
  import cpr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire cpr_req_t host_req,
  input wire cpr_rsp_t host_rsp,
  input wire logic [5:0] reg_addr,
  input wire logic rx_analog_off,
  input wire logic soft_sleep,
  input wire logic cmd_start,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_done,
  input wire logic [6:0] irq_flags,
  input wire logic irq_pin
);
  // ==========================================
  // shadow state
  logic [2:0] pg;
  logic [7:0] ien;
  wire cw = host_req.wr && reg_addr == 6'h01;
  wire sw = cw && host_req.wdata[4];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pg <= 3'h0;
      ien <= 8'h80;
    end else if (host_req.wr) begin
      if (reg_addr[3:0] == 4'h0) pg <= {host_req.wdata[7], host_req.wdata[1:0]};
      if (reg_addr == 6'h02) ien <= host_req.wdata;
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_addr_form:
    assert property (reg_addr == (pg[2] ? {pg[1:0], host_req.pin_addr} : host_req.latch_addr)) else $error("bad addr");
  a_read_answer:
    assert property (host_req.rd |=> host_rsp.valid) else $error("read answer late");
  a_cmd_start:
    assert property (cw |=> cmd_start && cmd_code == $past(host_req.wdata[3:0])) else $error("cmd not started");
  a_cmd_finish:
    assert property (cmd_done && !cw |=> cmd_code == 4'h0) else $error("cmd not idle");
  a_rx_off:
    assert property (cw |=> rx_analog_off == $past(host_req.wdata[5])) else $error("rx off wrong");
  a_sleep_enter:
    assert property (sw && cmd_code != 4'hF |=> soft_sleep) else $error("sleep not entered");
  a_sleep_refused:
    assert property (sw && cmd_code == 4'hF && !soft_sleep |=> !soft_sleep) else $error("sleep not refused");
  a_wake_start:
    assert property (cw && !host_req.wdata[4] |=> !soft_sleep) else $error("wake not started");
  a_write_only:
    assert property (host_req.rd && reg_addr == 6'h0C |=> host_rsp.data == 8'h00) else $error("write-only read");
  a_irq_pin:
    assert property (##1 irq_pin == ($past(|(irq_flags & ien[6:0])) ^ $past(ien[7]))) else $error("irq pin wrong");
endmodule : cpr_bank_assertions

bind cpr_bank cpr_bank_assertions chk (.clock(clock), .resetn(resetn), .host_req(host_req),
  .host_rsp(host_rsp), .reg_addr(reg_addr), .rx_analog_off(rx_analog_off), .soft_sleep(soft_sleep),
  .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_done(cmd_done), .irq_flags(irq_flags), .irq_pin(irq_pin));

// ===== cpr_host_model.sv
// Purpose: host microcontroller model on the register port
// Assumes: requests launched at the falling edge, one per call
// Notes: released address and data fields show inverted values so stale data cannot pass
`timescale 1ns/100ps
module cpr_host_model
  import cpr_pkg::*;
(
  input wire logic clock,
  output cpr_req_t req,
  input wire cpr_rsp_t rsp
);
  initial req = '0;
  // data is the caller's; reserved ones only in deliberate refusal cases
  // production test registers are never addressed
  task automatic access(input logic w, input logic [5:0] a, input logic [3:0] p, input logic [7:0] d,
    output logic [8:0] q);
    @(negedge clock);
    req = '{wr: w, rd: !w, latch_addr: a, pin_addr: p, wdata: d};
    @(negedge clock);
    q = {rsp.valid, rsp.data};
    req = '{wr: 1'b0, rd: 1'b0, latch_addr: ~a, pin_addr: ~p, wdata: ~d};
  endtask : access
endmodule : cpr_host_model

// ===== testbench.sv
// Purpose: self-checking bench for cpr_bank
// Assumes: host model makes requests; bench drives status inputs
// Notes: one-cycle read latency, so no polling is needed
`timescale 1ns/100ps
module testbench
  import cpr_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [5:0] a;
    logic [7:0] d;
  } cpr_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_done = 1'b0;
  logic wake_ready = 1'b0;
  logic [6:0] flags = 7'h00;
  logic cksum = 1'b1;
  logic hit_exp;
  logic rx_off, sleep, start, irq, fstb;
  logic [3:0] code;
  logic [5:0] reg_addr;
  logic [7:0] fdata;
  logic [8:0] q;
  cpr_req_t req;
  cpr_rsp_t rsp;
  int error_cnt = 0;
  int compares = 0;
  // reads compare against d; reset values first
  cpr_row_t rows [13] = '{'{1'b0, 6'h00, 8'h00}, '{1'b0, 6'h01, 8'h20}, '{1'b0, 6'h02, 8'h80},
    '{1'b1, 6'h02, 8'h55}, '{1'b0, 6'h02, 8'h55}, '{1'b1, 6'h01, 8'hEC}, '{1'b0, 6'h01, 8'h2C},
    '{1'b1, 6'h0C, 8'hFF}, '{1'b0, 6'h0C, 8'h00}, '{1'b1, 6'h0B, 8'hFE}, '{1'b0, 6'h0B, 8'h01},
    '{1'b1, 6'h05, 8'hFF}, '{1'b0, 6'h05, 8'h00}};
  cpr_host_model host (.clock(clock), .req(req), .rsp(rsp));
  cpr_bank dut (.clock(clock), .resetn(resetn), .host_req(req), .host_rsp(rsp), .reg_addr(reg_addr),
    .rx_analog_off(rx_off), .soft_sleep(sleep), .cmd_start(start), .cmd_code(code), .cmd_done(cmd_done),
    .wake_ready(wake_ready), .checksum_done_flag(cksum), .irq_flags(flags), .irq_pin(irq),
    .flag_force_strobe(fstb), .flag_force_data(fdata));
  initial forever #2.5 clock = ~clock;
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [5:0] a, input logic [3:0] p, input logic [7:0] e, input string n);
    host.access(1'b0, a, p, 8'h00, q);
    chk(n, {1'b1, e}, q);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [3:0] p, input logic [7:0] d);
    host.access(1'b1, a, p, d, q);
  endtask : wr
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // ==========================================
  // watchdog: a hang counts as a mismatch
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, 4'h0, rows[i].d);
      end else begin
        rd(rows[i].a, 4'h0, rows[i].d, "row read");
        // page select, command, enable, status and force offsets belong to this bank
        hit_exp = rows[i].a == 6'h00 || rows[i].a == 6'h01 || rows[i].a == 6'h02 ||
          rows[i].a == 6'h0B || rows[i].a == 6'h0C;
        chk("row hit", {8'h00, hit_exp}, {8'h00, rsp.hit});
      end
    end
    $display("register rows done");
    cmd_done = 1'b1;
    @(negedge clock);
    cmd_done = 1'b0;
    rd(6'h01, 4'h0, 8'h20, "command idle");
    wr(6'h01, 4'h0, 8'h10);
    chk("sleep", 9'h001, {8'h00, sleep});
    chk("rx off", 9'h000, {8'h00, rx_off});
    wr(6'h01, 4'h0, 8'h00);
    chk("sleep off", 9'h000, {8'h00, sleep});
    rd(6'h01, 4'h0, 8'h10, "waking");
    wake_ready = 1'b1;
    @(negedge clock);
    wake_ready = 1'b0;
    rd(6'h01, 4'h0, 8'h00, "awake");
    wr(6'h01, 4'h0, 8'h0F);
    chk("cmd start", 9'h001, {8'h00, start});
    wr(6'h01, 4'h0, 8'h1F);
    chk("sleep refused", 9'h000, {8'h00, sleep});
    rd(6'h01, 4'h0, 8'h0F, "reinit running");
    $display("power test done");
    wr(6'h00, 4'h0, 8'h80);
    rd(6'h3F, 4'h2, 8'h55, "page 0 pins");
    wr(6'h3F, 4'h0, 8'hFD);
    rd(6'h3F, 4'h2, 8'h00, "page 1 gap");
    rd(6'h3F, 4'h0, 8'h81, "page select");
    wr(6'h3F, 4'h0, 8'h00);
    rd(6'h02, 4'hF, 8'h55, "latch only");
    $display("page test done");
    flags = 7'h01;
    wr(6'h02, 4'h0, 8'h54);
    @(negedge clock);
    chk("irq masked", 9'h000, {8'h00, irq});
    wr(6'h02, 4'h0, 8'h81);
    @(negedge clock);
    chk("irq flipped", 9'h000, {8'h00, irq});
    wr(6'h02, 4'h0, 8'h80);
    @(negedge clock);
    chk("irq idle flipped", 9'h001, {8'h00, irq});
    $display("irq test done");
    // the strobe stands for the one cycle after the write, the data until the next one
    wr(6'h0C, 4'h0, 8'hA5);
    chk("force strobe", 9'h001, {8'h00, fstb});
    chk("force data", 9'h0A5, {1'b0, fdata});
    cksum = 1'b0;
    rd(6'h0B, 4'h0, 8'h00, "status clear");
    chk("force idle", 9'h000, {8'h00, fstb});
    $display("force and status test done");
    // mid-run reset: command F and rx on must fall back to the reset values
    resetn = 1'b0;
    @(negedge clock);
    chk("reset code", 9'h000, {5'h00, code});
    chk("reset rx off", 9'h001, {8'h00, rx_off});
    chk("reset irq", 9'h001, {8'h00, irq});
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    rd(6'h00, 4'h0, 8'h00, "reset page");
    rd(6'h01, 4'h0, 8'h20, "reset command");
    rd(6'h02, 4'h0, 8'h80, "reset enable");
    $display("reset test done");
    summarize();
  end
endmodule : testbench
